// >>> shared/adf_pkg.sv
// shared constants and types for the audio dac serial front end
package adf_pkg;
  localparam int POR_CYCLES       = 1024;
  localparam int ZERO_PERIODS     = 1024;
  localparam int LOSS_BIT_PERIODS = 3;
  localparam int SAMPLE_W         = 24;
  localparam int CTRL_WORD_BITS   = 16;
  localparam int IDX_W            = 7;
  localparam int DATA_W           = 8;
  localparam int GAP_W            = 16;
  localparam int FRAME_W          = 8;
  localparam int HALF_W           = 7;

  localparam logic [6:0] IDX_FORMAT = 7'h14;
  localparam logic [6:0] IDX_FLAGS  = 7'h16;

  localparam int FMT_LSB          = 0;
  localparam int FMT_W            = 3;
  localparam int FLAG_PHASE_BIT   = 0;
  localparam int FLAG_INVERT_BIT  = 1;
  localparam int FLAG_COMBINE_BIT = 2;
  localparam int FLAG_W           = 3;

  typedef enum logic [2:0] {
    FMT_RJ24 = 3'h0,
    FMT_RJ20 = 3'h1,
    FMT_RJ18 = 3'h2,
    FMT_RJ16 = 3'h3,
    FMT_I2S  = 3'h4,
    FMT_LJ24 = 3'h5
  } adf_fmt_t;

  localparam logic [2:0] FORMAT_RST = 3'h5;
  localparam logic [2:0] FLAGS_RST  = 3'h0;

  typedef enum logic [1:0] {
    JUST_RJ  = 2'h0,
    JUST_I2S = 2'h1,
    JUST_LJ  = 2'h2
  } adf_just_t;

  typedef enum logic [1:0] {
    ST_HELD   = 2'b00,
    ST_TRAIN  = 2'b01,
    ST_LOCKED = 2'b11
  } adf_lock_t;
endpackage

// >>> shared/adf_link_if.sv
// carrier between the front end core, its control port and its zero detector
`timescale 1ns/1ps
interface adf_link_if;
  logic                                  shiftRise;
  logic                                  latchRise;
  logic                                  latchFall;
  logic                                  latchLow;
  logic                                  serialBit;
  logic                                  wrValid;
  logic [adf_pkg::IDX_W-1:0]             wrIndex;
  logic [adf_pkg::DATA_W-1:0]            wrData;
  logic [1:0]                            sampleStrobe;
  logic [1:0][adf_pkg::SAMPLE_W-1:0]     sampleData;
  logic [1:0]                            zeroDetect;

  modport core (output shiftRise, latchRise, latchFall, latchLow, serialBit,
                input wrValid, wrIndex, wrData,
                output sampleStrobe, sampleData, input zeroDetect);
  modport ctrl (input shiftRise, latchRise, latchFall, latchLow, serialBit,
                output wrValid, wrIndex, wrData);
  modport zero (input sampleStrobe, sampleData, output zeroDetect);
endinterface

// >>> hw/adf_ctrl_port.sv
// write-only three-wire control port: collects 16-bit index/data words
`timescale 1ns/1ps
module adf_ctrl_port (
  input  logic     clk,
  input  logic     sys_rst,
  adf_link_if.ctrl lnk
);
  logic [adf_pkg::CTRL_WORD_BITS-1:0] word_r;
  logic [4:0]                         bitCnt_r;
  logic                               wrValid_r;
  logic [adf_pkg::IDX_W-1:0]          wrIndex_r;
  logic [adf_pkg::DATA_W-1:0]         wrData_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      word_r   <= '0;
      bitCnt_r <= 5'h00;
    end
    else if (lnk.latchFall)
      bitCnt_r <= 5'h00;
    else if (lnk.shiftRise && lnk.latchLow)
    begin
      word_r <= {word_r[adf_pkg::CTRL_WORD_BITS-2:0], lnk.serialBit};
      if (bitCnt_r != 5'h1f)
        bitCnt_r <= bitCnt_r + 5'h01;
    end
  end

  // a word counts only with exactly sixteen shifts and a clear leading bit
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wrValid_r <= 1'b0;
      wrIndex_r <= '0;
      wrData_r  <= '0;
    end
    else
    begin
      wrValid_r <= lnk.latchRise && (bitCnt_r == 5'h10)
                   && !word_r[adf_pkg::CTRL_WORD_BITS-1];
      if (lnk.latchRise)
      begin
        wrIndex_r <= word_r[adf_pkg::DATA_W +: adf_pkg::IDX_W];
        wrData_r  <= word_r[adf_pkg::DATA_W-1:0];
      end
    end
  end

  assign lnk.wrValid = wrValid_r;
  assign lnk.wrIndex = wrIndex_r;
  assign lnk.wrData  = wrData_r;
endmodule // adf_ctrl_port

// >>> hw/adf_zero_detect.sv
// per-channel run length of all-zero samples
`timescale 1ns/1ps
module adf_zero_detect #(
  parameter int ZERO_PERIODS = adf_pkg::ZERO_PERIODS
) (
  input  logic     clk,
  input  logic     sys_rst,
  adf_link_if.zero lnk
);
  localparam int CW = $clog2(ZERO_PERIODS + 1);

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : gChan
      logic [CW-1:0] run_r;
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          run_r <= '0;
        else if (lnk.sampleStrobe[ch])
        begin
          if (lnk.sampleData[ch] != '0)
            run_r <= '0;
          else if (run_r != CW'(ZERO_PERIODS))
            run_r <= run_r + 1'b1;
        end
      end
      assign lnk.zeroDetect[ch] = (run_r == CW'(ZERO_PERIODS));
    end
  endgenerate
endmodule // adf_zero_detect

// >>> hw/adf_audio_front_end.sv
// digital front end of a stereo audio dac: serial audio receiver and control
`timescale 1ns/1ps
module adf_audio_front_end #(
  parameter bit HW_VARIANT = 1'b0,
  parameter int POR_CYCLES = adf_pkg::POR_CYCLES
) (
  input  logic                         clk,
  input  logic                         sys_rst,
  input  logic                         serialBitClock,
  input  logic                         wordSelectClock,
  input  logic                         serialDataIn,
  input  logic                         controlLatchStrobe,
  input  logic                         controlShiftClock,
  input  logic                         controlSerialIn,
  input  logic                         formatSelectPin,
  input  logic                         deemphasisSelect,
  input  logic                         muteSelect,
  output logic [adf_pkg::SAMPLE_W-1:0] leftSample,
  output logic [adf_pkg::SAMPLE_W-1:0] rightSample,
  output logic                         leftSampleValid,
  output logic                         rightSampleValid,
  output logic                         processingHeld,
  output logic                         resetActive,
  output logic [adf_pkg::FMT_W-1:0]    formatField,
  output logic                         flagPolarityInvert,
  output logic                         flagCombineSelect,
  output logic                         outputPhaseReverse,
  output logic                         deemphasisOn,
  output logic                         muteOn,
  output logic                         oversample64,
  output logic                         leftZeroFlag,
  output logic                         rightZeroFlag,
  output logic                         sharedZeroFlag
);
  localparam int NPIN   = 9;
  localparam int P_BCK  = 0;
  localparam int P_WORD_SELECT_CLOCK = 1;
  localparam int P_DATA = 2;
  localparam int P_ML   = 3;
  localparam int P_MC   = 4;
  localparam int P_MD   = 5;
  localparam int P_FMT  = 6;
  localparam int P_DEEMPHASIS_SELECT = 7;
  localparam int P_MUTE = 8;
  localparam int PW     = $clog2(POR_CYCLES + 1);
  localparam int SW     = adf_pkg::SAMPLE_W;

  logic [NPIN-1:0] pinIn;
  logic [NPIN-1:0] pinLvl;
  logic [NPIN-1:0] pinRise;
  logic [NPIN-1:0] pinFall;

  assign pinIn = {muteSelect, deemphasisSelect, formatSelectPin,
                  controlSerialIn, controlShiftClock, controlLatchStrobe,
                  serialDataIn, wordSelectClock, serialBitClock};

  // every pin is foreign to clk; a level is accepted once stages two and three
  // agree, so a single sampled glitch on a clock pin never makes an edge
  genvar g;
  generate
    for (g = 0; g < NPIN; g++)
    begin : gSync
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic lvl_r;
      always_ff @(posedge clk)
      begin
        // the latch strobe idles high; resetting its stages high keeps a false
        // latch edge from following every reset
        if (sys_rst)
        begin
          s1_r  <= (g == P_ML);
          s2_r  <= (g == P_ML);
          s3_r  <= (g == P_ML);
          lvl_r <= (g == P_ML);
        end
        else
        begin
          s1_r <= pinIn[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r)
            lvl_r <= s3_r;
        end
      end
      assign pinLvl[g]  = lvl_r;
      assign pinRise[g] = (s2_r == s3_r) & s3_r & ~lvl_r;
      assign pinFall[g] = (s2_r == s3_r) & ~s3_r & lvl_r;
    end
  endgenerate

  logic bckRise;
  logic lrckRise;
  logic lrckEdge;
  logic lrckLvl;

  assign bckRise  = pinRise[P_BCK];
  assign lrckRise = pinRise[P_WORD_SELECT_CLOCK];
  assign lrckEdge = pinRise[P_WORD_SELECT_CLOCK] | pinFall[P_WORD_SELECT_CLOCK];
  assign lrckLvl  = pinLvl[P_WORD_SELECT_CLOCK];

  // power-on hold
  logic [PW-1:0] porCnt_r;
  logic          porDone;

  assign porDone = (porCnt_r == PW'(POR_CYCLES));

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      porCnt_r <= '0;
    else if (!porDone)
      porCnt_r <= porCnt_r + 1'b1;
  end

  // control registers
  adf_link_if lnk ();

  logic [adf_pkg::FMT_W-1:0]  formatField_r;
  logic [adf_pkg::FLAG_W-1:0] flags_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      formatField_r <= adf_pkg::FORMAT_RST;
      flags_r       <= adf_pkg::FLAGS_RST;
    end
    else if (lnk.wrValid && !HW_VARIANT)
    begin
      case (lnk.wrIndex)
        adf_pkg::IDX_FORMAT:
          formatField_r <= lnk.wrData[adf_pkg::FMT_LSB +: adf_pkg::FMT_W];
        adf_pkg::IDX_FLAGS:
          flags_r <= lnk.wrData[adf_pkg::FLAG_W-1:0];
        default:
          flags_r <= flags_r;
      endcase
    end
  end

  assign formatField        = formatField_r;
  assign flagPolarityInvert = !HW_VARIANT && flags_r[adf_pkg::FLAG_INVERT_BIT];
  assign flagCombineSelect  = !HW_VARIANT && flags_r[adf_pkg::FLAG_COMBINE_BIT];
  assign outputPhaseReverse = !HW_VARIANT && flags_r[adf_pkg::FLAG_PHASE_BIT];

  // format decode
  adf_pkg::adf_just_t just;
  logic [4:0]         wordBits;
  logic [4:0]         alignShift;

  always_comb
  begin
    just     = adf_pkg::JUST_LJ;
    wordBits = 5'd24;
    if (HW_VARIANT)
    begin
      if (pinLvl[P_FMT])
      begin
        just     = adf_pkg::JUST_RJ;
        wordBits = 5'd16;
      end
      else
        just = adf_pkg::JUST_I2S;
    end
    else
    begin
      case (adf_pkg::adf_fmt_t'(formatField_r))
        adf_pkg::FMT_RJ24: just = adf_pkg::JUST_RJ;
        adf_pkg::FMT_RJ20:
        begin
          just     = adf_pkg::JUST_RJ;
          wordBits = 5'd20;
        end
        adf_pkg::FMT_RJ18:
        begin
          just     = adf_pkg::JUST_RJ;
          wordBits = 5'd18;
        end
        adf_pkg::FMT_RJ16:
        begin
          just     = adf_pkg::JUST_RJ;
          wordBits = 5'd16;
        end
        adf_pkg::FMT_I2S:  just = adf_pkg::JUST_I2S;
        default:           just = adf_pkg::JUST_LJ;
      endcase
    end
  end

  assign alignShift  = 5'd24 - wordBits;

  // serial receiver
  logic [SW-1:0]              shift_r;
  logic [SW-1:0]              shiftNxt;
  logic [adf_pkg::HALF_W-1:0] halfCnt_r;
  logic [adf_pkg::HALF_W-1:0] target;
  logic                       captured_r;
  logic                       capNow;
  logic [SW-1:0]              capSrc;
  logic [adf_pkg::HALF_W-1:0] capGap;
  logic [SW-1:0]              aligned;
  logic                       halfIsLeft;

  assign shiftNxt   = {shift_r[SW-2:0], pinLvl[P_DATA]};
  assign target     = adf_pkg::HALF_W'(wordBits) + (just == adf_pkg::JUST_I2S ? 7'h01 : 7'h00);
  assign halfIsLeft = (just == adf_pkg::JUST_I2S) ? ~lrckLvl : lrckLvl;

  // right-justified words end at the word clock edge; the others start there,
  // and a half too short for the whole word is still taken at the next edge
  always_comb
  begin
    capNow = 1'b0;
    capSrc = shift_r;
    capGap = 7'h00;
    if (lrckEdge)
    begin
      if (just == adf_pkg::JUST_RJ)
        capNow = 1'b1;
      else if (!captured_r)
      begin
        capNow = 1'b1;
        if (halfCnt_r < target)
          capGap = target - halfCnt_r;
      end
    end
    else if (bckRise && just != adf_pkg::JUST_RJ && !captured_r
             && (halfCnt_r + 7'h01) == target)
    begin
      capNow = 1'b1;
      capSrc = shiftNxt;
    end
  end

  assign aligned = (capSrc << capGap) << alignShift;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      shift_r    <= '0;
      halfCnt_r  <= '0;
      captured_r <= 1'b0;
    end
    else if (lrckEdge)
    begin
      halfCnt_r  <= '0;
      captured_r <= 1'b0;
    end
    else
    begin
      if (bckRise)
      begin
        shift_r <= shiftNxt;
        if (halfCnt_r != '1)
          halfCnt_r <= halfCnt_r + 1'b1;
      end
      if (capNow)
        captured_r <= 1'b1;
    end
  end

  // lock monitor: bit clock stall and frame length
  logic [adf_pkg::GAP_W-1:0]   bckGap_r;
  logic [adf_pkg::GAP_W-1:0]   bckPeriod_r;
  logic [adf_pkg::GAP_W+1:0]   lossLimit;
  logic [adf_pkg::FRAME_W-1:0] frameBits_r;
  logic [adf_pkg::FRAME_W-1:0] lastFrame_r;
  logic                        bckStall;
  logic                        lossNow;
  adf_pkg::adf_lock_t          lockState_r;

  assign lossLimit = (adf_pkg::GAP_W + 2)'(bckPeriod_r * adf_pkg::LOSS_BIT_PERIODS);
  assign bckStall  = (bckPeriod_r != '0) && ({2'b00, bckGap_r} >= lossLimit);
  assign lossNow   = bckStall || (frameBits_r == '1);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bckGap_r    <= '0;
      bckPeriod_r <= '0;
    end
    else if (bckRise)
    begin
      bckPeriod_r <= bckGap_r + 1'b1;
      bckGap_r    <= '0;
    end
    else if (bckGap_r != '1)
      bckGap_r <= bckGap_r + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      frameBits_r <= '0;
      lastFrame_r <= '0;
    end
    else if (lrckRise)
    begin
      lastFrame_r <= frameBits_r;
      frameBits_r <= '0;
    end
    else if (bckRise && frameBits_r != '1)
      frameBits_r <= frameBits_r + 1'b1;
  end

  // one clean frame after the first word clock rise is enough to resume,
  // which keeps recovery under three sample periods
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      lockState_r <= adf_pkg::ST_HELD;
    else
    begin
      case (lockState_r)
        adf_pkg::ST_HELD:
          if (porDone && !lossNow && lrckRise)
            lockState_r <= adf_pkg::ST_TRAIN;
        adf_pkg::ST_TRAIN:
          if (lossNow)
            lockState_r <= adf_pkg::ST_HELD;
          else if (lrckRise)
            lockState_r <= adf_pkg::ST_LOCKED;
        adf_pkg::ST_LOCKED:
          if (lossNow || (lrckRise && frameBits_r != lastFrame_r))
            lockState_r <= adf_pkg::ST_HELD;
        default:
          lockState_r <= adf_pkg::ST_HELD;
      endcase
    end
  end

  // holding registers; mid-scale zero whenever processing is not running
  logic          running;
  logic [SW-1:0] leftSample_r;
  logic [SW-1:0] rightSample_r;
  logic          leftValid_r;
  logic          rightValid_r;

  assign running = porDone && (lockState_r == adf_pkg::ST_LOCKED);

  always_ff @(posedge clk)
  begin
    if (sys_rst || !running)
    begin
      leftSample_r  <= '0;
      rightSample_r <= '0;
      leftValid_r   <= 1'b0;
      rightValid_r  <= 1'b0;
    end
    else
    begin
      leftValid_r  <= capNow && halfIsLeft;
      rightValid_r <= capNow && !halfIsLeft;
      if (capNow && halfIsLeft)
        leftSample_r <= aligned;
      if (capNow && !halfIsLeft)
        rightSample_r <= aligned;
    end
  end

  assign leftSample       = leftSample_r;
  assign rightSample      = rightSample_r;
  assign leftSampleValid  = leftValid_r;
  assign rightSampleValid = rightValid_r;
  assign processingHeld   = (lockState_r != adf_pkg::ST_LOCKED);
  assign resetActive      = !porDone;

  // control port and zero detection
  assign lnk.shiftRise    = pinRise[P_MC];
  assign lnk.latchRise    = pinRise[P_ML];
  assign lnk.latchFall    = pinFall[P_ML];
  assign lnk.latchLow     = ~pinLvl[P_ML];
  assign lnk.serialBit    = pinLvl[P_MD];
  assign lnk.sampleStrobe = {rightValid_r, leftValid_r};
  assign lnk.sampleData   = {rightSample_r, leftSample_r};

  adf_ctrl_port u_ctrl (
    .clk     (clk),
    .sys_rst (sys_rst),
    .lnk     (lnk.ctrl)
  );

  adf_zero_detect u_zero (
    .clk     (clk),
    .sys_rst (sys_rst),
    .lnk     (lnk.zero)
  );

  logic bothZero;
  logic leftZero_r;
  logic rightZero_r;
  logic sharedZero_r;
  logic deemphasis_select_r;
  logic mute_r;

  assign bothZero = lnk.zeroDetect[0] & lnk.zeroDetect[1];

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      leftZero_r   <= 1'b0;
      rightZero_r  <= 1'b0;
      sharedZero_r <= 1'b0;
      deemphasis_select_r       <= 1'b0;
      mute_r       <= 1'b0;
    end
    else
    begin
      leftZero_r   <= (flagCombineSelect ? bothZero : lnk.zeroDetect[0])
                      ^ flagPolarityInvert;
      rightZero_r  <= (flagCombineSelect ? bothZero : lnk.zeroDetect[1])
                      ^ flagPolarityInvert;
      sharedZero_r <= bothZero;
      deemphasis_select_r       <= HW_VARIANT && pinLvl[P_DEEMPHASIS_SELECT];
      mute_r       <= HW_VARIANT && pinLvl[P_MUTE];
    end
  end

  assign leftZeroFlag   = leftZero_r;
  assign rightZeroFlag  = rightZero_r;
  assign sharedZeroFlag = sharedZero_r;
  assign deemphasisOn   = deemphasis_select_r;
  assign muteOn         = mute_r;
  // the modulator rate is fixed; there is no second rate in this front end
  assign oversample64   = 1'b1;
endmodule // adf_audio_front_end

// >>> bench/adf_fe_asserts.sv
// concurrent checks on the audio front end top ports
`timescale 1ns/1ps
module adf_fe_asserts #(
  parameter int POR_CYCLES = 1024
) (
  input logic        clk,
  input logic        sys_rst,
  input logic        serialBitClock,
  input logic        controlLatchStrobe,
  input logic [23:0] leftSample,
  input logic        leftSampleValid,
  input logic        rightSampleValid,
  input logic        processingHeld,
  input logic        resetActive,
  input logic [2:0]  formatField,
  input logic        flagPolarityInvert,
  input logic        flagCombineSelect,
  input logic        leftZeroFlag,
  input logic        rightZeroFlag,
  input logic        sharedZeroFlag
);
  logic [7:0]  stallCnt_r;
  logic [15:0] porCnt_r;
  logic        bitClkLast_r;

  // 80 idle cycles is far past three bit periods plus the pin filter delay
  always_ff @(posedge clk)
  begin
    bitClkLast_r <= serialBitClock;
    if (sys_rst || serialBitClock != bitClkLast_r)
      stallCnt_r <= 8'h00;
    else if (stallCnt_r != 8'hff)
      stallCnt_r <= stallCnt_r + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst || !resetActive)
      porCnt_r <= 16'h0000;
    else
      porCnt_r <= porCnt_r + 16'h0001;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_por_hold;
    $fell(sys_rst) |=> resetActive [*8];
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("reset hold ended early");

  property p_por_end;
    32'(porCnt_r) <= POR_CYCLES + 2;
  endproperty
  a_por_end: assert property (p_por_end) else $error("reset hold too long");

  property p_mid_scale;
    resetActive |-> leftSample == 24'h0 && !leftSampleValid && !rightSampleValid;
  endproperty
  a_mid_scale: assert property (p_mid_scale) else $error("output during hold");

  property p_valid_locked;
    leftSampleValid || rightSampleValid |-> !processingHeld;
  endproperty
  a_valid_locked: assert property (p_valid_locked) else $error("sample while held");

  property p_stall;
    stallCnt_r == 8'h50 |-> processingHeld;
  endproperty
  a_stall: assert property (p_stall) else $error("stall not held");

  property p_pulse;
    leftSampleValid |=> !leftSampleValid [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("word transfers too close");

  property p_fmt_latch;
    $changed(formatField) |-> controlLatchStrobe && $past(controlLatchStrobe, 2);
  endproperty
  a_fmt_latch: assert property (p_fmt_latch) else $error("format moved off latch");

  property p_combine;
    flagCombineSelect && $stable(flagCombineSelect) |-> leftZeroFlag == rightZeroFlag;
  endproperty
  a_combine: assert property (p_combine) else $error("combined flags differ");

  property p_shared;
    flagCombineSelect && $stable(flagCombineSelect) && $stable(flagPolarityInvert)
      |-> sharedZeroFlag == (leftZeroFlag != flagPolarityInvert);
  endproperty
  a_shared: assert property (p_shared) else $error("flag polarity wrong");

  c_capture: cover property (leftSampleValid);
  c_relock: cover property ($fell(processingHeld));
  c_write: cover property ($changed(formatField));
endmodule // adf_fe_asserts

bind adf_audio_front_end adf_fe_asserts #(.POR_CYCLES(POR_CYCLES)) chk_u (
  .clk(clk), .sys_rst(sys_rst), .serialBitClock(serialBitClock),
  .controlLatchStrobe(controlLatchStrobe), .leftSample(leftSample),
  .leftSampleValid(leftSampleValid), .rightSampleValid(rightSampleValid),
  .processingHeld(processingHeld), .resetActive(resetActive), .formatField(formatField),
  .flagPolarityInvert(flagPolarityInvert), .flagCombineSelect(flagCombineSelect),
  .leftZeroFlag(leftZeroFlag), .rightZeroFlag(rightZeroFlag),
  .sharedZeroFlag(sharedZeroFlag));

// >>> bench/adf_audio_src.sv
// behavioural audio source: 64-slot frames, left-justified, right-justified or i2s
`timescale 1ns/1ps
module adf_audio_src (
  input  logic        run,
  input  logic        i2sMode,
  input  logic        rjMode,
  input  logic [23:0] leftWord,
  input  logic [23:0] rightWord,
  output logic        bitClk,
  output logic        wordClk,
  output logic        dataOut
);
  int          slot;
  logic [63:0] frame;

  // 64 slots a frame is the one bit rate legal for every format
  always_comb
  begin
    if (i2sMode)
      frame = {1'b0, leftWord, 8'h00, rightWord, 7'h00};
    else if (rjMode)
      frame = {8'h00, leftWord, 8'h00, rightWord};
    else
      frame = {leftWord, 8'h00, rightWord, 8'h00};
  end

  // data moves on the falling bit clock; the clock freezes while stopped
  // and picks up at the top of a frame, so no word clock edge lands mid-frame
  // bit and word clock come from one timer and stay in step
  initial
  begin
    bitClk = 1'b0;
    wordClk = 1'b1;
    dataOut = 1'b0;
    slot = 0;
    forever
    begin
      #24;
      if (run)
      begin
        bitClk = ~bitClk;
        if (!bitClk)
        begin
          slot = (slot + 1) % 64;
          wordClk = i2sMode ? (slot >= 32) : (slot < 32);
          dataOut = frame[63 - slot];
        end
      end
      else
        slot = 63;
    end
  end
endmodule // adf_audio_src

// >>> bench/adf_audio_front_end_tb.sv
// self-checking bench for the audio front end
`timescale 1ns/1ps
module adf_audio_front_end_tb;
  localparam int POR = 16;
  logic        clk, sys_rst, run, i2sMode, bitClk, wordClk, dataLine;
  logic        latch, shiftClk, ctrlBit, rjMode, deemphasisOn, muteOn;
  logic [23:0] leftSample, rightSample, leftWord, rightWord;
  logic [2:0]  formatField;
  logic        leftSampleValid, rightSampleValid, processingHeld, resetActive;
  logic        flagPolarityInvert, flagCombineSelect, outputPhaseReverse, oversample64;
  logic        leftZeroFlag, rightZeroFlag, sharedZeroFlag;
  logic [3:0]  watch;
  int          nErrors, nTests;

  assign watch = {resetActive, rightSampleValid, leftSampleValid, processingHeld};

  adf_audio_src src_u (.run(run), .i2sMode(i2sMode), .rjMode(rjMode), .leftWord(leftWord),
    .rightWord(rightWord), .bitClk(bitClk), .wordClk(wordClk), .dataOut(dataLine));

  adf_audio_front_end #(.HW_VARIANT(1'b0), .POR_CYCLES(POR)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .serialBitClock(bitClk), .wordSelectClock(wordClk),
    .serialDataIn(dataLine), .controlLatchStrobe(latch), .controlShiftClock(shiftClk),
    .controlSerialIn(ctrlBit), .formatSelectPin(1'b0), .deemphasisSelect(1'b1),
    .muteSelect(1'b1), .leftSample(leftSample), .rightSample(rightSample),
    .leftSampleValid(leftSampleValid), .rightSampleValid(rightSampleValid),
    .processingHeld(processingHeld), .resetActive(resetActive), .formatField(formatField),
    .flagPolarityInvert(flagPolarityInvert), .flagCombineSelect(flagCombineSelect),
    .outputPhaseReverse(outputPhaseReverse), .deemphasisOn(deemphasisOn), .muteOn(muteOn),
    .oversample64(oversample64), .leftZeroFlag(leftZeroFlag),
    .rightZeroFlag(rightZeroFlag), .sharedZeroFlag(sharedZeroFlag));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // a wait that runs out ends the run at once
  task automatic waitFor(input int idx, input logic lvl, input int lim);
    int k;
    k = 0;
    while (watch[idx] !== lvl && k < lim)
    begin
      tick(1);
      k++;
    end
    check(24'(watch[idx]), 24'(lvl));
    if (watch[idx] !== lvl)
      printVerdict();
  endtask

  // shift clock of 100 ns; data is set up half a period before each rise
  task automatic ctrlWrite(input logic [15:0] w);
    latch = 1'b0;
    tick(4);
    for (int i = 15; i >= 0; i--)
    begin
      ctrlBit = w[i];
      tick(10);
      shiftClk = 1'b1;
      tick(10);
      shiftClk = 1'b0;
    end
    tick(4);
    latch = 1'b1;
    tick(12);
  endtask

  // a right word first, so the left word checked is always whole
  task automatic chkPair();
    waitFor(2, 1'b1, 800);
    tick(1);
    waitFor(1, 1'b1, 800);
    check(leftSample, leftWord);
    tick(1);
    waitFor(2, 1'b1, 800);
    check(rightSample, rightWord);
  endtask

  initial
  begin
    nErrors = 0;
    nTests = 0;
    sys_rst = 1'b1;
    run = 1'b0;
    i2sMode = 1'b0;
    rjMode = 1'b0;
    latch = 1'b1;
    shiftClk = 1'b0;
    ctrlBit = 1'b0;
    leftWord = 24'h123456;
    rightWord = 24'h8a5c31;
    tick(2);
    check(24'(formatField), 24'h5);
    check(24'(oversample64), 24'h1);
    check(24'({flagPolarityInvert, flagCombineSelect, leftZeroFlag}), 24'h0);
    sys_rst = 1'b0;
    tick(1);
    check(24'({resetActive, processingHeld}), 24'h3);
    tick(POR - 4);
    check(leftSample, 24'h0);
    check(24'({deemphasisOn, muteOn}), 24'h0);
    waitFor(3, 1'b0, 6);
    $display("reset test done");
    for (int f = 0; f < 6; f++)
    begin
      ctrlWrite({8'h14, 8'(f)});
      check(24'(formatField), 24'(f));
    end
    ctrlWrite(16'h1504);
    check(24'(formatField), 24'h5);
    ctrlWrite(16'h9404);
    check(24'(formatField), 24'h5);
    ctrlWrite(16'h1606);
    check(24'({flagPolarityInvert, flagCombineSelect, outputPhaseReverse}), 24'h6);
    check(24'({leftZeroFlag, rightZeroFlag, sharedZeroFlag}), 24'h6);
    ctrlWrite(16'h1600);
    check(24'({leftZeroFlag, rightZeroFlag}), 24'h0);
    $display("control test done");
    run = 1'b1;
    waitFor(0, 1'b0, 3000);
    chkPair();
    $display("left-justified test done");
    run = 1'b0;
    waitFor(0, 1'b1, 100);
    ctrlWrite(16'h1404);
    i2sMode = 1'b1;
    run = 1'b1;
    waitFor(0, 1'b0, 1850);
    chkPair();
    $display("stall and i2s test done");
    run = 1'b0;
    waitFor(0, 1'b1, 100);
    ctrlWrite(16'h1400);
    i2sMode = 1'b0;
    rjMode = 1'b1;
    run = 1'b1;
    waitFor(0, 1'b0, 1850);
    chkPair();
    $display("right-justified test done");
    printVerdict();
  end
endmodule // adf_audio_front_end_tb
